//--- rtl/corner_bender.sv
// Eight-by-eight format converter: rotating load of eight shift registers,
// proportional delay lines and a small output buffer.
// Assumes one core clock for bus and highways; inputs synchronous to it.
//
// Operation
// R1 - Serial and parallel sides share one clock
// R2 - Each clock loads exactly one register, rotating
// R3 - Loaded register shifts one bit per clock
// R4 - Emptying register reloads same edge, no gaps
// R5 - Channel delays seven down to zero clocks
// R6 - Delayed outputs leave aligned in one slot
// R7 - Preloadable three-bit counter counts eight clocks
// R8 - Sync pulse loads preload value into counter
// R9 - Sync tied to clock: preload selects directly
// R10 - Selection uses counter value from previous edge
// R11 - 3-to-8 decode gives one load strobe
// R12 - Same path converts serial to parallel
// R13 - Output words take serial inputs in rotation
// R14 - Word n bit k on line k
// R15 - Eight bits of one input form word
// R16 - Synchronous binary counter with parallel load
// R17 - Reset clears counter, shift and delay registers
`timescale 1ns/100ps
module corner_bender
	import corner_bender_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// Parallel bus side
	input wire logic i_word_valid,
	input wire logic [WORD_W-1:0] i_word,
	output logic o_word_ready,
	// Counter preload and sync
	input wire sync_cmd_t i_sync_cmd,
	// Aligned slot side
	output logic o_slot_valid,
	output slot_t o_slot,
	input wire logic i_slot_ready,
	// Status
	output logic [SEL_W-1:0] o_sel
);

	// ----------------------------------------------------------------
	// Advance enable
	// ----------------------------------------------------------------
	// The whole converter moves as one pipeline: a missing word or a full
	// buffer freezes the counter, shift and delay registers, so slot alignment is never broken.
	wire logic buf_ready;
	wire logic advance;

	assign advance = i_word_valid && buf_ready; // [R1]
	assign o_word_ready = buf_ready;

	// ----------------------------------------------------------------
	// Select counter and decoder
	// ----------------------------------------------------------------
	logic [SEL_W-1:0] sel_ff;
	wire logic [SEL_W-1:0] nxt_sel;
	wire logic [LANES-1:0] load_stb;

	// Preload wins over the count; with sync held high it tracks preload
	assign nxt_sel = i_sync_cmd.sync ? i_sync_cmd.preload : sel_ff + SEL_STEP; // [R7] [R8] [R9] [R16]
	// Strobe follows the counter state captured on the previous edge
	assign load_stb = sel_decode(sel_ff); // [R10] [R11]

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
			sel_ff <= SEL_RESET; // [R17]
		else if (advance)
			sel_ff <= nxt_sel; // [R7] [R16]
	end

	assign o_sel = sel_ff;

	// ----------------------------------------------------------------
	// Eight shift registers
	// ----------------------------------------------------------------
	// Bit 0 leaves first. A register's last bit leaves on the edge where
	// the rotation returns to it, so the reload lands in that same edge.
	logic [WORD_W-1:0] shreg_ff [LANES];
	logic [WORD_W-1:0] nxt_shreg [LANES];
	logic [LANES-1:0] chan_bit;

	always_comb
	begin
		for (int j = 0; j < LANES; j++)
		begin
			nxt_shreg[j] = load_stb[j] ? i_word : {SHIFT_FILL, shreg_ff[j][WORD_W-1:1]}; // [R2] [R3] [R4]
			chan_bit[j] = shreg_ff[j][0];
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
		begin
			for (int j = 0; j < LANES; j++)
				shreg_ff[j] <= WORD_RESET; // [R17]
		end
		else if (advance)
		begin
			for (int j = 0; j < LANES; j++)
				shreg_ff[j] <= nxt_shreg[j]; // [R2] [R3]
		end
	end

	// ----------------------------------------------------------------
	// Proportional delay lines
	// ----------------------------------------------------------------
	// Register j is loaded j clocks after register 0, so it is held back
	// by LANE_LAST - j clocks; the last lane needs no delay at all.
	// The result is a corner turn: slot t carries bit t of the eight words
	// of one rotation, and equally the eight bits of serial input t.
	logic [LANES-1:0] aligned;

	genvar g;
	generate
		for (g = 0; g < LANE_LAST; g++)
		begin : g_delay
			lane_delay #(
				.DEPTH(LANE_LAST - g)
			) u_delay (
				.i_core_clk(i_core_clk),
				.i_rst_b(i_rst_b),
				.i_adv(advance),
				.i_bit(chan_bit[g]),
				.o_bit(aligned[g])
			); // [R5] [R17]
		end
	endgenerate

	assign aligned[LANE_LAST] = chan_bit[LANE_LAST]; // [R5]

	// ----------------------------------------------------------------
	// Output buffer
	// ----------------------------------------------------------------
	slot_t slot_in;

	assign slot_in.bits = aligned; // [R6] [R12] [R13] [R14] [R15]

	slot_buffer #(
		.WIDTH($bits(slot_t)),
		.DEPTH(BUF_DEPTH)
	) u_buffer (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_wr_valid(advance),
		.i_wr_data(slot_in),
		.o_wr_ready(buf_ready),
		.o_rd_valid(o_slot_valid),
		.o_rd_data(o_slot),
		.i_rd_ready(i_slot_ready)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);

	sequence s_run7;
		advance [*7];
	endsequence

	sequence s_free_rotation;
		(advance && !i_sync_cmd.sync) [*8];
	endsequence

	sequence s_free7;
		(advance && !i_sync_cmd.sync) [*7];
	endsequence

	chk_one_strobe: assert property (advance |-> $onehot(load_stb)) // [R11]
		else $error("load strobe is not one-hot");

	chk_count_step: assert property (advance && !i_sync_cmd.sync |=> sel_ff == $past(sel_ff) + SEL_STEP) // [R7]
		else $error("select counter did not step by one");

	chk_preload_take: assert property (advance && i_sync_cmd.sync |=> sel_ff == $past(i_sync_cmd.preload)) // [R8]
		else $error("sync did not load preload value");

	chk_stall_hold: assert property (!advance |=> $stable(sel_ff) && $stable(aligned)) // [R1]
		else $error("converter moved while stalled");

	chk_load_word: assert property (advance |=> shreg_ff[$past(sel_ff)] == $past(i_word)) // [R2]
		else $error("selected register missed the bus word");

	chk_shift_step: assert property (advance && !load_stb[0] |=> shreg_ff[0] == {SHIFT_FILL, $past(shreg_ff[0][WORD_W-1:1])}) // [R3]
		else $error("register zero did not shift by one");

	chk_gapless_reload: assert property (s_free_rotation |=> load_stb == $past(load_stb, 8)) // [R4]
		else $error("rotation did not return after eight loads");

	chk_lane_align: assert property (s_run7 ##1 1'b1 |-> aligned[0] == $past(chan_bit[0], 7)) // [R5]
		else $error("lane zero delay is not seven clocks");

	chk_last_direct: assert property (advance && load_stb[LANE_LAST] |=> // [R5]
		aligned[LANE_LAST] == $past(i_word[0]))
		else $error("last lane is delayed");

	chk_slot_corner: assert property (s_run7 ##1 1'b1 |-> aligned[1] == $past(chan_bit[1], 6)) // [R6]
		else $error("lane one out of alignment");

	chk_reset_clear: assert property (disable iff (1'b0) !i_rst_b |=> sel_ff == SEL_RESET && shreg_ff[0] == WORD_RESET) // [R17]
		else $error("reset did not clear converter");

	chk_buffer_push: assert property (advance |=> o_slot_valid) // [R13]
		else $error("slot not delivered to buffer");

	// ----------------------------------------------------------------
	// Per-register shift checks
	// ----------------------------------------------------------------
	// Every register that is not being loaded moves one bit toward its
	// serial output; a stuck or doubled shift breaks the corner turn.
	chk_shift_reg1: assert property (advance && !load_stb[1] |=> // [R3]
		shreg_ff[1] == {SHIFT_FILL, $past(shreg_ff[1][WORD_W-1:1])})
		else $error("register one did not shift by one");

	chk_shift_reg2: assert property (advance && !load_stb[2] |=> // [R3]
		shreg_ff[2] == {SHIFT_FILL, $past(shreg_ff[2][WORD_W-1:1])})
		else $error("register two did not shift by one");

	chk_shift_reg3: assert property (advance && !load_stb[3] |=> // [R3]
		shreg_ff[3] == {SHIFT_FILL, $past(shreg_ff[3][WORD_W-1:1])})
		else $error("register three did not shift by one");

	chk_shift_reg4: assert property (advance && !load_stb[4] |=> // [R3]
		shreg_ff[4] == {SHIFT_FILL, $past(shreg_ff[4][WORD_W-1:1])})
		else $error("register four did not shift by one");

	chk_shift_reg5: assert property (advance && !load_stb[5] |=> // [R3]
		shreg_ff[5] == {SHIFT_FILL, $past(shreg_ff[5][WORD_W-1:1])})
		else $error("register five did not shift by one");

	chk_shift_reg6: assert property (advance && !load_stb[6] |=> // [R3]
		shreg_ff[6] == {SHIFT_FILL, $past(shreg_ff[6][WORD_W-1:1])})
		else $error("register six did not shift by one");

	chk_shift_reg7: assert property (advance && !load_stb[7] |=> // [R3]
		shreg_ff[7] == {SHIFT_FILL, $past(shreg_ff[7][WORD_W-1:1])})
		else $error("register seven did not shift by one");

	// ----------------------------------------------------------------
	// Delay line checks
	// ----------------------------------------------------------------
	// Lane j is held back by LANE_LAST - j advances, counted in advances
	// rather than clocks because a stall freezes the delay lines too.
	chk_lane2_align: assert property (s_run7 ##1 1'b1 |-> // [R5]
		aligned[2] == $past(chan_bit[2], 5))
		else $error("lane two delay is not five clocks");

	chk_lane3_align: assert property (s_run7 ##1 1'b1 |-> // [R5]
		aligned[3] == $past(chan_bit[3], 4))
		else $error("lane three delay is not four clocks");

	chk_lane4_align: assert property (s_run7 ##1 1'b1 |-> // [R5]
		aligned[4] == $past(chan_bit[4], 3))
		else $error("lane four delay is not three clocks");

	chk_lane5_align: assert property (s_run7 ##1 1'b1 |-> // [R6]
		aligned[5] == $past(chan_bit[5], 2))
		else $error("lane five delay is not two clocks");

	chk_lane6_align: assert property (s_run7 ##1 1'b1 |-> // [R6]
		aligned[6] == $past(chan_bit[6], 1))
		else $error("lane six delay is not one clock");

	// ----------------------------------------------------------------
	// Gapless reload checks
	// ----------------------------------------------------------------
	// After a load and seven free advances the register shows the last bit
	// of its word and is selected again, so the reload meets that bit.
	chk_reload_reg0: assert property ((advance && !i_sync_cmd.sync && load_stb[0]) ##1 s_free7 |=> // [R4]
		chan_bit[0] == $past(i_word[WORD_W-1], 8) && load_stb[0])
		else $error("register zero was not reloaded as its last bit left");

	chk_reload_reg1: assert property ((advance && !i_sync_cmd.sync && load_stb[1]) ##1 s_free7 |=> // [R4]
		chan_bit[1] == $past(i_word[WORD_W-1], 8) && load_stb[1])
		else $error("register one was not reloaded as its last bit left");

	chk_reload_reg2: assert property ((advance && !i_sync_cmd.sync && load_stb[2]) ##1 s_free7 |=> // [R4]
		chan_bit[2] == $past(i_word[WORD_W-1], 8) && load_stb[2])
		else $error("register two was not reloaded as its last bit left");

	chk_reload_reg3: assert property ((advance && !i_sync_cmd.sync && load_stb[3]) ##1 s_free7 |=> // [R4]
		chan_bit[3] == $past(i_word[WORD_W-1], 8) && load_stb[3])
		else $error("register three was not reloaded as its last bit left");

	chk_reload_reg4: assert property ((advance && !i_sync_cmd.sync && load_stb[4]) ##1 s_free7 |=> // [R4]
		chan_bit[4] == $past(i_word[WORD_W-1], 8) && load_stb[4])
		else $error("register four was not reloaded as its last bit left");

	chk_reload_reg5: assert property ((advance && !i_sync_cmd.sync && load_stb[5]) ##1 s_free7 |=> // [R4]
		chan_bit[5] == $past(i_word[WORD_W-1], 8) && load_stb[5])
		else $error("register five was not reloaded as its last bit left");

	chk_reload_reg6: assert property ((advance && !i_sync_cmd.sync && load_stb[6]) ##1 s_free7 |=> // [R4]
		chan_bit[6] == $past(i_word[WORD_W-1], 8) && load_stb[6])
		else $error("register six was not reloaded as its last bit left");

	chk_reload_reg7: assert property ((advance && !i_sync_cmd.sync && load_stb[7]) ##1 s_free7 |=> // [R4]
		chan_bit[7] == $past(i_word[WORD_W-1], 8) && load_stb[7])
		else $error("register seven was not reloaded as its last bit left");

	// ----------------------------------------------------------------
	// Counter and sync checks
	// ----------------------------------------------------------------
	chk_count_wrap: assert property (advance && !i_sync_cmd.sync && sel_ff == SEL_W'(LANE_LAST) |=> // [R7]
		sel_ff == SEL_RESET)
		else $error("select counter did not wrap after eight loads");

	chk_preload_select: assert property ((advance && i_sync_cmd.sync) ##1 advance |=> // [R10]
		shreg_ff[$past(i_sync_cmd.preload, 2)] == $past(i_word))
		else $error("load did not follow the previous preload");

	chk_sync_ignored: assert property (!advance && i_sync_cmd.sync |=> // [R8]
		sel_ff == $past(sel_ff))
		else $error("sync moved the counter without a load");

	// ----------------------------------------------------------------
	// Stall, buffer and reset checks
	// ----------------------------------------------------------------
	// The receiver may hold off for any time; nothing may be lost or
	// reordered while the buffer is full.
	chk_stall_regs: assert property (!advance |=> // [R1]
		$stable(chan_bit) && $stable(o_sel))
		else $error("shift registers moved while stalled");

	chk_full_stays: assert property (!o_word_ready && !i_slot_ready |=> // [R1]
		!o_word_ready && o_slot_valid)
		else $error("full buffer changed while the receiver held off");

	chk_pop_frees: assert property (!o_word_ready && i_slot_ready |=> // [R1]
		o_word_ready)
		else $error("buffer stayed full after a slot was taken");

	chk_slot_hold: assert property (o_slot_valid && !i_slot_ready |=> // [R13]
		o_slot_valid && $stable(o_slot))
		else $error("waiting slot changed before it was taken");

	chk_reset_lanes: assert property (disable iff (1'b0) !i_rst_b |=> // [R17]
		aligned == '0 && !o_slot_valid && o_word_ready)
		else $error("reset left the delay lines or buffer busy");

endmodule : corner_bender

//--- rtl/corner_bender_pkg.sv
// Shared constants, carrier types and the select decoder of the format converter.
// Assumes a single core clock; nothing here holds state.
package corner_bender_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int LANES = 8;
	localparam int WORD_W = 8;
	localparam int SEL_W = 3;
	localparam int LANE_LAST = 7;
	localparam int BUF_DEPTH = 2;

	// ----------------------------------------------------------------
	// Reset values and counter step
	// ----------------------------------------------------------------
	localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
	localparam logic [SEL_W-1:0] SEL_STEP = 3'h1;
	localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
	localparam logic [LANES-1:0] STB_BASE = 8'h01;
	localparam logic SHIFT_FILL = 1'b0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int HIGHWAY_KBPS = 2048;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sync;
		logic [SEL_W-1:0] preload;
	} sync_cmd_t;

	typedef struct packed {
		logic [LANES-1:0] bits;
	} slot_t;

	// ----------------------------------------------------------------
	// 3-to-8 decode of the select counter into load strobes
	// ----------------------------------------------------------------
	function automatic logic [LANES-1:0] sel_decode(input logic [SEL_W-1:0] sel);
		sel_decode = STB_BASE << sel;
	endfunction : sel_decode

endpackage : corner_bender_pkg

//--- rtl/lane_delay.sv
// Fixed-depth one-bit delay line that steps only on the advance enable.
// Assumes depth of at least one; a zero-delay lane is wired around it.
`timescale 1ns/100ps
module lane_delay
	import corner_bender_pkg::*;
#(
	parameter int DEPTH = 1
)
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// Stream
	input wire logic i_adv,
	input wire logic i_bit,
	output logic o_bit
);

	logic [DEPTH-1:0] pipe_ff;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
			pipe_ff <= '0;
		else if (i_adv)
		begin
			pipe_ff[0] <= i_bit;
			for (int i = 1; i < DEPTH; i++)
				pipe_ff[i] <= pipe_ff[i-1];
		end
	end

	assign o_bit = pipe_ff[DEPTH-1];

endmodule : lane_delay

//--- rtl/slot_buffer.sv
// Small FIFO of flip-flops between the aligned slot stream and its receiver.
// Assumes the writer honours o_wr_ready; a full buffer stalls the converter.
`timescale 1ns/100ps
module slot_buffer
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
)
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// Write side
	input wire logic i_wr_valid,
	input wire logic [WIDTH-1:0] i_wr_data,
	output logic o_wr_ready,
	// Read side
	output logic o_rd_valid,
	output logic [WIDTH-1:0] o_rd_data,
	input wire logic i_rd_ready
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
	localparam logic [PTR_W:0] CNT_FULL = (PTR_W + 1)'(DEPTH);
	localparam logic [PTR_W:0] CNT_ONE = (PTR_W + 1)'(1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PTR_W-1:0] wr_ptr_ff;
	logic [PTR_W-1:0] rd_ptr_ff;
	logic [PTR_W:0] count_ff;
	wire logic push;
	wire logic pop;

	assign o_wr_ready = (count_ff != CNT_FULL);
	assign o_rd_valid = (count_ff != '0);
	assign push = i_wr_valid && o_wr_ready;
	assign pop = o_rd_valid && i_rd_ready;
	assign o_rd_data = mem_ff[rd_ptr_ff];

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			for (int i = 0; i < DEPTH; i++)
				mem_ff[i] <= '0;
		end
		else
		begin
			if (push)
			begin
				mem_ff[wr_ptr_ff] <= i_wr_data;
				wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + PTR_ONE;
			end
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + PTR_ONE;
			if (push && !pop)
				count_ff <= count_ff + CNT_ONE;
			else if (pop && !push)
				count_ff <= count_ff - CNT_ONE;
		end
	end

endmodule : slot_buffer

//--- testbench/slot_sink.sv
// Receiver model standing at the far side of the converter's slot buffer.
// Assumes the shared core clock; ready moves only at the falling edge.
`timescale 1ns/100ps
module slot_sink
	import corner_bender_pkg::*;
(
	// Clock and mode
	input wire logic i_core_clk,
	input wire logic [1:0] i_mode,
	// Slot stream
	input wire logic i_valid,
	input wire slot_t i_slot,
	output logic o_ready
);
	slot_t got[$];
	logic [1:0] cnt_ff;
	initial
	begin
		o_ready = 1'b0;
		cnt_ff = 2'h0;
	end
	// ------------------------------------------------------------
	// Mode 0 always takes, 1 stalls one cycle in three, 2 never
	// ------------------------------------------------------------
	always @(negedge i_core_clk)
	begin
		cnt_ff <= (cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
		o_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && cnt_ff != 2'h0);
	end
	// Same clock as the parallel side; same rate only in mode 0
	always @(posedge i_core_clk)
	begin
		if (i_valid === 1'b1 && o_ready === 1'b1)
			got.push_back(i_slot);
	end
endmodule : slot_sink

//--- testbench/corner_bender_test.sv
// Self-checking bench for the format converter.
// Assumes the slot_sink model takes the slots; inputs move at falling edges.
`timescale 1ns/100ps
module corner_bender_test
	import corner_bender_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic word_valid = 1'b0;
	logic [7:0] word = 8'h00;
	logic word_ready;
	sync_cmd_t sync_cmd = 4'h0;
	logic slot_valid;
	slot_t slot;
	logic slot_ready;
	logic [2:0] sel;
	logic [1:0] mode = 2'h0;
	logic [7:0] wds[64];
	logic [7:0] lines[8];
	int n_fail = 0;
	int num_checks = 0;

	corner_bender i_dut (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_word_valid(word_valid),
		.i_word(word), .o_word_ready(word_ready), .i_sync_cmd(sync_cmd), .o_slot_valid(slot_valid),
		.o_slot(slot), .i_slot_ready(slot_ready), .o_sel(sel));
	slot_sink i_sink (.i_core_clk(core_clk), .i_mode(mode), .i_valid(slot_valid), .i_slot(slot),
		.o_ready(slot_ready));

	initial
	begin
		forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask : check

	task automatic do_reset;
		@(negedge core_clk);
		rst_b = 1'b0;
		repeat (10) @(negedge core_clk);
		check({5'h0, sel}, 8'h00);
		check({6'h0, slot_valid, word_ready}, 8'h01);
		rst_b = 1'b1;
		i_sink.got.delete();
	endtask : do_reset

	// Holds the word until an edge with ready high takes it, giving up after 50 edges
	task automatic send(input logic [7:0] w);
		logic rdy;
		word_valid = 1'b1;
		word = w;
		for (int k = 0; k < 50; k++)
		begin
			rdy = word_ready;
			@(posedge core_clk);
			@(negedge core_clk);
			if (rdy === 1'b1)
				break;
		end
	endtask : send

	// Slot 8+t of each group of eight holds bit t of its eight words
	task automatic run_stream(input int n);
		int b;
		logic [7:0] exp;
		for (int i = 0; i < n; i++)
		begin
			send(wds[i]);
			check({5'h0, sel}, 8'((i + 1) % 8));
		end
		word_valid = 1'b0;
		for (int k = 0; k < 100 && i_sink.got.size() < n; k++)
			@(negedge core_clk);
		check(8'(i_sink.got.size()), 8'(n));
		for (int p = 8; p < n && p < i_sink.got.size(); p++)
		begin
			b = ((p - 8) / 8) * 8;
			for (int j = 0; j < 8; j++)
				exp[j] = wds[b + j][(p - 8) % 8];
			check(i_sink.got[p].bits, exp);
		end
	endtask : run_stream

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_stream(input logic [1:0] m);
		do_reset();
		mode = m;
		for (int i = 0; i < 32; i++)
			wds[i] = 8'h3c ^ 8'(i * 37);
		run_stream(32);
	endtask : test_stream

	task automatic test_full;
		do_reset();
		mode = 2'h2;
		send(8'h11);
		send(8'h22);
		repeat (3) @(negedge core_clk);
		check({5'h0, sel}, 8'h02);
		check({7'h0, word_ready}, 8'h00);
		word_valid = 1'b0;
		mode = 2'h0;
	endtask : test_full

	task automatic test_sync;
		do_reset();
		sync_cmd = {1'b1, 3'h5};
		send(8'ha5);
		sync_cmd = 4'h0;
		check({5'h0, sel}, 8'h05);
		sync_cmd = {1'b1, 3'h2};
		word_valid = 1'b0;
		repeat (2) @(negedge core_clk);
		check({5'h0, sel}, 8'h05);
		for (int v = 0; v < 8; v++)
		begin
			sync_cmd = {1'b1, 3'(v * 3)};
			send(8'(v));
			check({5'h0, sel}, 8'(v * 3 % 8));
		end
		word_valid = 1'b0;
		sync_cmd = 4'h0;
	endtask : test_sync

	task automatic test_serial;
		do_reset();
		for (int k = 0; k < 8; k++)
			lines[k] = 8'ha1 + 8'(k * 19);
		for (int n = 0; n < 16; n++)
			for (int k = 0; k < 8; k++)
				wds[n][k] = (n < 8) ? lines[k][n] : 1'b0;
		run_stream(16);
		for (int t = 0; t < 8; t++)
			check(i_sink.got[8 + t].bits, lines[t]);
	endtask : test_serial

	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		finish_test();
	end

	initial
	begin
		test_stream(2'h0);
		test_stream(2'h1);
		test_full();
		test_sync();
		test_serial();
		finish_test();
	end
endmodule : corner_bender_test
